// >>> radio_switch_receiver_hang_timer.sv
`timescale 1ns/100ps
`include "rx_switch_defines.svh"

// Functional notes
// - receiver modes always listen, never transmit
// - outputs copy the packet's three logic bits
// - strap low: clear outputs 500 ms later
// - new packet updates outputs at once
// - strap high: hang time is 20 ms
// - strap 1,0,1 selects networked 500 ms
// - strap 1,1,0 selects open 20 ms
// - strap 1,1,1 selects networked 20 ms
// - open 500 ms mode accepts every packet
// - learn pin pulse learns, then drives LED
// - switch outputs are active high
// - networked mode drops unlearned serial numbers
// - all-zero logic byte clears outputs now
module radio_switch_receiver_hang_timer #(
    parameter int HANG_LONG_CYCLES =
        `RSW_HANG_LONG_MS * (`RSW_CLK_HZ / 1000),
    parameter int HANG_SHORT_CYCLES =
        `RSW_HANG_SHORT_MS * (`RSW_CLK_HZ / 1000),
    parameter int LEARN_CYCLES = `RSW_LEARN_MS * (`RSW_CLK_HZ / 1000),
    parameter int TABLE_DEPTH = `RSW_TABLE_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [2:0] i_mode_sel,
    input wire logic i_pkt_valid,
    input wire logic [7:0] i_pkt_logic,
    input wire logic [`RSW_SERIAL_W-1:0] i_pkt_serial_number_id,
    input wire logic i_learn_status,
    output logic o_learn_status,
    output logic o_learn_status_oe,
    output logic o_switch_output_a,
    output logic o_switch_output_b,
    output logic o_switch_output_c,
    output logic o_rx_active,
    output logic o_mode_valid
);
    localparam int CW = 32;

    // refuse counts the timers cannot serve
    if (HANG_LONG_CYCLES < 1 || HANG_SHORT_CYCLES < 1 ||
        LEARN_CYCLES < 1) begin : g_bad_count
        $error("radio_switch_receiver: counts must be positive");
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] mode_meta_ff;
    logic [2:0] mode_ff;
    logic learn_meta_ff;
    logic learn_ff;
    logic learn_prev_ff;

    // straps and learn pin come from outside, two flops before use
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            mode_meta_ff <= 3'h0;
            mode_ff <= 3'h0;
            learn_meta_ff <= 1'b0;
            learn_ff <= 1'b0;
            learn_prev_ff <= 1'b0;
        end else begin
            mode_meta_ff <= i_mode_sel;
            mode_ff <= mode_meta_ff;
            learn_meta_ff <= i_learn_status;
            learn_ff <= learn_meta_ff;
            learn_prev_ff <= learn_ff;
        end
    end

    // ****************************************************************
    // mode decode
    // ****************************************************************
    wire rx_mode = mode_ff[`RSW_SEL_RX];
    wire networked = rx_mode && mode_ff[`RSW_SEL_NET];
    wire open_mode = rx_mode && !mode_ff[`RSW_SEL_NET];
    wire short_hang = mode_ff[`RSW_SEL_SHORT];
    wire [CW-1:0] hang_limit = short_hang ? CW'(HANG_SHORT_CYCLES) :
        CW'(HANG_LONG_CYCLES);
    wire learn_rise = learn_ff && !learn_prev_ff;
    wire learn_fall = !learn_ff && learn_prev_ff;

    // ****************************************************************
    // packet stage and serial number table
    // ****************************************************************
    logic pend_ff;
    logic [2:0] pend_bits_ff;
    logic pend_zero_ff;
    logic [`RSW_SERIAL_W-1:0] pend_serial_ff;
    logic known;
    logic table_full;
    rx_switch_pkg::learn_state_t lstate_ff;
    logic [CW-1:0] lcnt_ff;

    wire learning = (lstate_ff == rx_switch_pkg::LRN_ACTIVE);
    // learning adds the header serial of a packet not yet known
    wire teach = pend_ff && networked && learning && !known && !table_full;
    // open modes take all; networked takes known or just-taught serials
    wire accept = pend_ff && (open_mode || (networked && (known || teach)));

    // hold the packet one cycle while the table answers
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            pend_ff <= 1'b0;
            pend_bits_ff <= 3'h0;
            pend_zero_ff <= 1'b0;
            pend_serial_ff <= '0;
        end else begin
            pend_ff <= i_pkt_valid && rx_mode;
            pend_bits_ff <= i_pkt_logic[`RSW_LOGIC_HI:`RSW_LOGIC_LO];
            pend_zero_ff <= (i_pkt_logic == 8'h00);
            pend_serial_ff <= i_pkt_serial_number_id;
        end
    end

    serial_table #(
        .DEPTH(TABLE_DEPTH),
        .W(`RSW_SERIAL_W)
    ) u_table (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_wr_en(teach),
        .i_wr_data(pend_serial_ff),
        .i_cmp_data(i_pkt_serial_number_id),
        .o_hit(known),
        .o_full(table_full)
    );

    // ****************************************************************
    // learn/status pin
    // ****************************************************************
    rx_switch_pkg::learn_state_t nxt_lstate;
    logic [CW-1:0] nxt_lcnt;

    // pin is an input until the pulse ends, then lights while learning;
    // the window closes on timeout or when the table fills
    always_comb begin
        nxt_lstate = lstate_ff;
        nxt_lcnt = lcnt_ff;
        unique case (lstate_ff)
            rx_switch_pkg::LRN_IDLE: begin
                if (networked && learn_rise) begin
                    nxt_lstate = rx_switch_pkg::LRN_ARMED;
                end
            end
            rx_switch_pkg::LRN_ARMED: begin
                if (!networked) begin
                    nxt_lstate = rx_switch_pkg::LRN_IDLE;
                end else if (learn_fall) begin
                    nxt_lstate = rx_switch_pkg::LRN_ACTIVE;
                    nxt_lcnt = '0;
                end
            end
            rx_switch_pkg::LRN_ACTIVE: begin
                nxt_lcnt = lcnt_ff + CW'(1);
                if (!networked || table_full ||
                    lcnt_ff >= CW'(LEARN_CYCLES - 1)) begin
                    nxt_lstate = rx_switch_pkg::LRN_IDLE;
                end
            end
            default: nxt_lstate = rx_switch_pkg::LRN_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            lstate_ff <= rx_switch_pkg::LRN_IDLE;
            lcnt_ff <= '0;
        end else begin
            lstate_ff <= nxt_lstate;
            lcnt_ff <= nxt_lcnt;
        end
    end

    // ****************************************************************
    // switch outputs and hang timer
    // ****************************************************************
    logic [2:0] sw_ff;
    logic run_ff;
    logic [CW-1:0] hang_ff;
    logic [2:0] nxt_sw;
    logic nxt_run;
    logic [CW-1:0] nxt_hang;

    // silence from the far end ends a hold, as do an accepted all-zero packet and a strap without the receiver bit
    always_comb begin
        nxt_sw = sw_ff;
        nxt_run = run_ff;
        nxt_hang = hang_ff;
        if (!rx_mode) begin
            nxt_sw = 3'h0;
            nxt_run = 1'b0;
        end else if (accept && pend_zero_ff) begin
            nxt_sw = 3'h0;
            nxt_run = 1'b0;
        end else if (accept) begin
            nxt_sw = pend_bits_ff;
            nxt_run = 1'b1;
            nxt_hang = CW'(1);
        end else if (run_ff) begin
            nxt_hang = hang_ff + CW'(1);
            if (hang_ff >= hang_limit) begin
                nxt_sw = 3'h0;
                nxt_run = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            sw_ff <= 3'h0;
            run_ff <= 1'b0;
            hang_ff <= '0;
        end else begin
            sw_ff <= nxt_sw;
            run_ff <= nxt_run;
            hang_ff <= nxt_hang;
        end
    end

    // ****************************************************************
    // registered status outputs
    // ****************************************************************
    logic led_ff;
    logic led_oe_ff;
    logic rx_on_ff;
    logic mode_ok_ff;

    // open modes never drive the pin; it floats there
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            led_ff <= 1'b0;
            led_oe_ff <= 1'b0;
            rx_on_ff <= 1'b0;
            mode_ok_ff <= 1'b0;
        end else begin
            led_ff <= (nxt_lstate == rx_switch_pkg::LRN_ACTIVE);
            led_oe_ff <= networked &&
                (nxt_lstate == rx_switch_pkg::LRN_ACTIVE);
            rx_on_ff <= rx_mode;
            mode_ok_ff <= rx_mode;
        end
    end

    assign o_switch_output_a = sw_ff[0];
    assign o_switch_output_b = sw_ff[1];
    assign o_switch_output_c = sw_ff[2];
    assign o_learn_status = led_ff;
    assign o_learn_status_oe = led_oe_ff;
    assign o_rx_active = rx_on_ff;
    assign o_mode_valid = mode_ok_ff;
endmodule

// >>> rx_switch_defines.svh
`ifndef RX_SWITCH_DEFINES_SVH
`define RX_SWITCH_DEFINES_SVH

// ****************************************************************
// timing figures
// ****************************************************************
`define RSW_CLK_HZ 10000000
`define RSW_HANG_LONG_MS 500
`define RSW_HANG_SHORT_MS 20
`define RSW_LEARN_MS 10000

// ****************************************************************
// strap bits and packet fields
// ****************************************************************
`define RSW_SEL_NET 0
`define RSW_SEL_SHORT 1
`define RSW_SEL_RX 2
`define RSW_LOGIC_LO 4
`define RSW_LOGIC_HI 6
`define RSW_SERIAL_W 32
`define RSW_TABLE_DEPTH 8

`endif

// >>> rx_switch_pkg.sv
package rx_switch_pkg;

    // learn/status pin sequencing
    typedef enum logic [1:0] {
        LRN_IDLE = 2'b00,
        LRN_ARMED = 2'b01,
        LRN_ACTIVE = 2'b10
    } learn_state_t;

endpackage

// >>> serial_table.sv
`timescale 1ns/100ps
`include "rx_switch_defines.svh"

module serial_table #(
    parameter int DEPTH = `RSW_TABLE_DEPTH,
    parameter int W = `RSW_SERIAL_W
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_en,
    input wire logic [W-1:0] i_wr_data,
    input wire logic [W-1:0] i_cmp_data,
    output logic o_hit,
    output logic o_full
);
    localparam int PW = $clog2(DEPTH + 1);

    // refuse sizes the table cannot serve
    if (DEPTH < 1 || W < 1) begin : g_bad_size
        $error("serial_table: DEPTH and W must be positive");
    end

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [W-1:0] entry_ff [DEPTH];
    logic [DEPTH-1:0] valid_ff;
    logic [DEPTH-1:0] match;
    logic [PW-1:0] count_ff;
    logic hit_ff;
    wire full = (count_ff == PW'(DEPTH));
    wire do_wr = i_wr_en && !full;

    // per-entry compare and write slot
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            assign match[g] = valid_ff[g] && (entry_ff[g] == i_cmp_data);
            always_ff @(posedge i_core_clk) begin
                if (!i_reset_n) begin
                    valid_ff[g] <= 1'b0;
                    entry_ff[g] <= '0;
                end else if (do_wr && count_ff == PW'(g)) begin
                    valid_ff[g] <= 1'b1;
                    entry_ff[g] <= i_wr_data;
                end
            end
        end
    endgenerate

    // fill pointer and registered lookup answer
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            count_ff <= '0;
            hit_ff <= 1'b0;
        end else begin
            count_ff <= do_wr ? count_ff + PW'(1) : count_ff;
            // a serial written this cycle counts as known, so a repeat
            // packet right behind it does not take a second slot
            hit_ff <= |match || (do_wr && i_wr_data == i_cmp_data);
        end
    end

    assign o_hit = hit_ff;
    assign o_full = full;
endmodule

// >>> radio_switch_receiver_hang_timer_monitor.sv
`timescale 1ns/100ps
// ********
// switch receiver checker
// ********
module radio_switch_receiver_hang_timer_monitor #(
    parameter int HANG_LONG_CYCLES = 50,
    parameter int HANG_SHORT_CYCLES = 10,
    parameter int LEARN_CYCLES = 200
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [2:0] i_mode_sel,
    input wire logic i_pkt_valid,
    input wire logic [7:0] i_pkt_logic,
    input wire logic o_learn_status,
    input wire logic o_learn_status_oe,
    input wire logic o_switch_output_a,
    input wire logic o_switch_output_b,
    input wire logic o_switch_output_c,
    input wire logic o_rx_active,
    input wire logic o_mode_valid
);
    logic [2:0] outs;
    int hang;
    int idle_ff;
    int lrn_ff;
    assign outs = {o_switch_output_c, o_switch_output_b, o_switch_output_a};
    assign hang = i_mode_sel[1] ? HANG_SHORT_CYCLES : HANG_LONG_CYCLES;
    // counts: cycles since a packet (saturates), cycles spent learning (does not saturate)
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || i_pkt_valid) begin
            idle_ff <= 0;
        end else if (idle_ff < 100000) begin
            idle_ff <= idle_ff + 1;
        end
        lrn_ff <= (!i_reset_n || !o_learn_status_oe) ? 0 : lrn_ff + 1;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    property p_mode_valid;
        o_mode_valid == o_rx_active;
    endproperty
    a_mode_valid: assert property (p_mode_valid)
        else $error("flags differ");
    property p_rx_follow;
        $stable(i_mode_sel)[*5] |-> o_rx_active == i_mode_sel[2];
    endproperty
    a_rx_follow: assert property (p_rx_follow)
        else $error("rx flag lags");
    property p_rx_off;
        (!o_rx_active)[*2] |-> outs == 3'h0;
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("outputs while off");
    // networked acceptance depends on the table, so open modes only
    property p_apply;
        i_pkt_valid && o_rx_active && !i_mode_sel[0]
            |-> ##2 outs == $past(i_pkt_logic[6:4], 2);
    endproperty
    a_apply: assert property (p_apply)
        else $error("bad output");
    property p_hang_clear;
        idle_ff > hang |-> outs == 3'h0;
    endproperty
    a_hang_clear: assert property (p_hang_clear)
        else $error("no clear");
    // an ignored networked packet would restart idle_ff, hence open only
    property p_hold;
        idle_ff > 1 && idle_ff <= hang && !i_mode_sel[0] |-> $stable(outs);
    endproperty
    a_hold: assert property (p_hold)
        else $error("early clear");
    property p_led_oe;
        o_learn_status == o_learn_status_oe;
    endproperty
    a_led_oe: assert property (p_led_oe)
        else $error("led vs drive");
    property p_oe_net;
        o_learn_status_oe |-> i_mode_sel[0];
    endproperty
    a_oe_net: assert property (p_oe_net)
        else $error("pin driven");
    property p_learn_max;
        lrn_ff <= LEARN_CYCLES;
    endproperty
    a_learn_max: assert property (p_learn_max)
        else $error("learn long");
endmodule

bind radio_switch_receiver_hang_timer radio_switch_receiver_hang_timer_monitor
    #(.HANG_LONG_CYCLES(HANG_LONG_CYCLES),
    .HANG_SHORT_CYCLES(HANG_SHORT_CYCLES), .LEARN_CYCLES(LEARN_CYCLES))
    u_monitor (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_mode_sel(i_mode_sel), .i_pkt_valid(i_pkt_valid),
    .i_pkt_logic(i_pkt_logic), .o_learn_status(o_learn_status),
    .o_learn_status_oe(o_learn_status_oe),
    .o_switch_output_a(o_switch_output_a),
    .o_switch_output_b(o_switch_output_b),
    .o_switch_output_c(o_switch_output_c),
    .o_rx_active(o_rx_active), .o_mode_valid(o_mode_valid));

// >>> remote_logic_tx.sv
`timescale 1ns/100ps
// ********
// remote logic transmitter
// ********
module remote_logic_tx (
    input wire logic i_core_clk,
    input wire logic [2:0] i_inputs,
    input wire logic [31:0] i_serial,
    input wire logic [7:0] i_period,
    output logic o_pkt_valid,
    output logic [7:0] o_pkt_logic,
    output logic [31:0] o_pkt_serial
);
    int gap = 0;
    // one packet, called at a falling edge, held one cycle
    task automatic send(input logic [7:0] b, input logic [31:0] s);
        o_pkt_valid = 1'b1;
        o_pkt_logic = b;
        o_pkt_serial = s;
        @(negedge i_core_clk);
    endtask
    // released lines show inverted data, never the stale packet
    task automatic idle();
        o_pkt_valid = 1'b0;
        o_pkt_logic = ~o_pkt_logic;
        o_pkt_serial = ~o_pkt_serial;
    endtask
    initial begin
        o_pkt_valid = 1'b0;
        o_pkt_logic = 8'h00;
        o_pkt_serial = 32'h0;
    end
    // refresh while any input is high, silent when all are low
    always begin
        @(negedge i_core_clk);
        if (|i_inputs && gap >= i_period) begin
            gap = 0;
            send({1'b0, i_inputs, 4'h0}, i_serial);
            idle();
        end else begin
            gap++;
        end
    end
endmodule

// >>> test_radio_switch_receiver_hang_timer.sv
`timescale 1ns/100ps
// ********
// switch receiver testbench
// ********
module test_radio_switch_receiver_hang_timer;
    localparam int HL = 50;
    localparam int HS = 10;
    localparam int LC = 200;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [2:0] i_mode_sel = 3'h4;
    logic [2:0] tx_in = 3'h0;
    logic ext_pin = 1'b0;
    logic pkt_valid, led, led_oe, out_a, out_b, out_c, rx_act, mode_ok;
    logic [7:0] pkt_logic, b;
    logic [31:0] pkt_sn, sn;
    logic [31:0] rng = 32'h00015597;
    int n_mismatch = 0, tests_run = 0, cyc = 0, h;
    // pull-down on the learn pin when nobody drives it; open modes
    // never pulse it
    wire pin = led_oe ? led : ext_pin;

    radio_switch_receiver_hang_timer #(.HANG_LONG_CYCLES(HL),
        .HANG_SHORT_CYCLES(HS), .LEARN_CYCLES(LC), .TABLE_DEPTH(8))
    u_radio_switch_receiver_hang_timer (.i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n), .i_mode_sel(i_mode_sel),
        .i_pkt_valid(pkt_valid), .i_pkt_logic(pkt_logic),
        .i_pkt_serial_number_id(pkt_sn), .i_learn_status(pin),
        .o_learn_status(led), .o_learn_status_oe(led_oe),
        .o_switch_output_a(out_a), .o_switch_output_b(out_b),
        .o_switch_output_c(out_c), .o_rx_active(rx_act),
        .o_mode_valid(mode_ok));
    remote_logic_tx u_remote_logic_tx (.i_core_clk(i_core_clk),
        .i_inputs(tx_in), .i_serial(sn), .i_period(8'h05),
        .o_pkt_valid(pkt_valid), .o_pkt_logic(pkt_logic),
        .o_pkt_serial(pkt_sn));

    always #50 i_core_clk = ~i_core_clk;
    // hang guard, well above the longest expected run
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [2:0] exp_out(logic [7:0] v);
        return v[6:4];
    endfunction
    task automatic wait_n(int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic chk_out(logic [2:0] e);
        tests_run++;
        if ({out_c, out_b, out_a} !== e) begin
            n_mismatch++;
            $display("wrong value outputs exp %h got %h", e,
                {out_c, out_b, out_a});
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %b got %b", n, e, g);
        end
    endtask
    // one packet, outputs settled on return
    task automatic pkt(logic [7:0] v, logic [31:0] s);
        u_remote_logic_tx.send(v, s);
        u_remote_logic_tx.idle();
        wait_n(1);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        wait_n(16);
        i_reset_n = 1'b1;
        for (int m = 4; m < 8; m++) begin
            i_mode_sel = m[2:0];
            h = i_mode_sel[1] ? HS : HL;
            wait_n(8);
            chk_bit("rx active", 1'b1, rx_act);
            chk_bit("mode valid", 1'b1, mode_ok);
            rng = xs(rng);
            sn = rng;
            if (!i_mode_sel[0]) begin
                chk_bit("learn drive", 1'b0, led_oe);
                // every combination, back to back, last one all-zero
                for (int k = 0; k < 8; k++) begin
                    rng = xs(rng);
                    b = (k == 7) ? 8'h00 : rng[15:8];
                    u_remote_logic_tx.send({rng[7], k[2:0], rng[3:0]}, rng);
                    u_remote_logic_tx.send(b, rng);
                    u_remote_logic_tx.idle();
                    chk_out(k[2:0]);
                    wait_n(1);
                    chk_out(exp_out(b));
                end
                pkt(8'h50, sn);
                wait_n(h - 1);
                chk_out(3'h5);
                wait_n(1);
                chk_out(3'h0);
                tx_in = rng[2:0] | 3'h1;
                wait_n(4 * h);
                chk_out(tx_in);
                tx_in = 3'h0;
                wait_n(h + 12);
                chk_out(3'h0);
            end else begin
                pkt(8'h70, ~sn);
                chk_out(3'h0);
                ext_pin = 1'b1;
                wait_n(4);
                ext_pin = 1'b0;
                wait_n(8);
                chk_bit("led", 1'b1, led);
                chk_bit("led drive", 1'b1, led_oe);
                pkt(8'h60, sn);
                chk_out(3'h6);
                wait_n(LC + 4);
                chk_bit("led", 1'b0, led);
                chk_bit("led drive", 1'b0, led_oe);
                pkt(8'h30, sn);
                chk_out(3'h3);
                pkt(8'h50, sn ^ 32'h1);
                chk_out(3'h3);
            end
            wait_n(HL + 10);
        end
        // a mid-run reset empties the learned serial table
        pkt(8'h30, sn);
        chk_out(3'h3);
        i_reset_n = 1'b0;
        wait_n(3);
        i_reset_n = 1'b1;
        wait_n(8);
        pkt(8'h30, sn);
        chk_out(3'h0);
        // strap without receiver bit leaves every output low
        i_mode_sel = 3'h0;
        wait_n(8);
        chk_bit("rx active", 1'b0, rx_act);
        chk_bit("mode valid", 1'b0, mode_ok);
        pkt(8'h70, sn);
        chk_out(3'h0);
        report_and_stop();
    end
endmodule
